// [dsau_regs.svh]
// constants of the data-space access unit: addresses, fields, reset values, timing
`ifndef DSAU_REGS_SVH
`define DSAU_REGS_SVH

// data address map
`define DSAU_SRAM_TOP 16'h03ff
`define DSAU_LOCK_ADDR 16'hfffc
`define DSAU_SRAM_AW 10

// data-memory enable encodings
`define DSAU_MAP_EXTERNAL 2'h0
`define DSAU_MAP_SRAM 2'h1
`define DSAU_MAP_RESERVED 2'h2
`define DSAU_MAP_LOCKED 2'h3
`define DSAU_MAP_RESET 2'h0

// stretch field
`define DSAU_STRETCH_RESET 3'h1
`define DSAU_STRETCH_SLOW 3'h4

// pointer select register fields
`define DSAU_SEL_BIT 0
`define DSAU_UNUSED_BIT 1
`define DSAU_TOGGLE_BIT 5
`define DSAU_DIR0_BIT 6
`define DSAU_DIR1_BIT 7
`define DSAU_SELECT_RESET 8'h00
`define DSAU_SELECT_MASK 8'he1

// timing in input clocks, extra movx lengths in machine cycles
`define DSAU_CLK_PER_MC 6'h04
`define DSAU_SRAM_CLOCKS 6'h08
`define DSAU_FAST_STROBE 6'h02
`define DSAU_FAST_ALE_END 6'h02
`define DSAU_SLOW_ALE_END 6'h06
`define DSAU_FAST_STROBE_AT 6'h04
`define DSAU_MID_STROBE_AT 6'h05
`define DSAU_SLOW_STROBE_AT 6'h0d
`define DSAU_FAST_EXTRA_MC 6'h02
`define DSAU_SLOW_EXTRA_MC 6'h05

`endif

// [dsau_pkg.sv]
// types shared by the data-space access unit
package dsau_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SRAM = 4'h2,
		ST_EXT = 4'h4,
		ST_LOCAL = 4'h8
	} dsau_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic usePointer;
		logic [15:0] addr;
		logic [7:0] wrData;
	} dsau_movx_t;

	typedef struct packed {
		logic [7:0] port0Out;
		logic port0Oe;
		logic [7:0] port2Out;
		logic ale;
		logic readStrobe_n;
		logic writeStrobe_n;
	} dsau_bus_t;

endpackage

// [dsau_access_unit.sv]
// data-space access unit: movx decode, on-chip sram, stretched bus, dual pointers
//
// What this block does
// - on-chip sram fixed at 0000h-03FFh when enabled
// - map 00 sends every movx to external bus
// - map 01: low 1kB internal, rest external
// - map 11: sram, no external, lock byte FFFCh
// - lock byte bits 2-0 read-only programmed lock
// - map bits apply to the next movx directly
// - internal sram movx always two machine cycles
// - three-bit stretch field, changeable any time
// - movx length and strobe width follow stretch
// - stretch resets to one, three-cycle movx
// - stretch one adds a clock setup, hold
// - stretch four lengthens ale, hold, strobe, data
// - above four only the strobe grows
// - stretch touches data movx only, not fetch
// - two 16-bit pointers, select bit zero chooses
// - pointer instructions use the selected pointer
// - bit one unused so increment toggles select
// - inc/dec active pointer by its direction bit
// - auto-toggle bit five flips select after each pointer instruction without a select write in the same cycle
// - operate on active pointer, then toggle
// - external movx on ports 0 and 2
`timescale 1ns/1ps
`include "dsau_regs.svh"

module dsau_access_unit #(
	parameter int SRAM_DEPTH = 1024
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// control register writes
	input wire logic mapWrite,
	input wire logic [1:0] mapIn,
	input wire logic stretchWrite,
	input wire logic [2:0] stretchIn,
	input wire logic selectWrite,
	input wire logic [7:0] selectIn,
	// pointer instructions
	input wire logic incPointer,
	input wire logic loadPointer,
	input wire logic [15:0] loadValue,
	input wire logic codeReadPointer,
	// movx request and answer
	input wire dsau_pkg::dsau_movx_t movxReq,
	output logic movxBusy,
	output logic movxDone,
	output logic [7:0] movxRdData,
	// lock fuses and external bus
	input wire logic [2:0] securityLockPins,
	input wire logic [7:0] port0In,
	output dsau_pkg::dsau_bus_t extBus,
	// register views
	output logic [1:0] dataMapSel,
	output logic [2:0] movxStretchField,
	output logic [7:0] pointerSelectReg,
	output logic [15:0] firstDataPointer,
	output logic [15:0] secondDataPointer,
	output logic [2:0] securityLockBits
);

	typedef struct packed {
		dsau_pkg::dsau_state_t state;
		logic busy;
		logic [5:0] cnt;
		logic [2:0] stretchUsed;
		logic write;
		logic lastExt;
		logic [15:0] addr;
		logic [7:0] wrData;
		logic done;
		logic [7:0] rdData;
		logic [1:0] mapSel;
		logic [2:0] stretch;
		logic [7:0] select;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
		logic [2:0] lockA;
		logic [2:0] lockB;
		logic [2:0] lockC;
		logic [2:0] lockStatus;
		logic [7:0] dataA;
		logic [7:0] dataB;
		logic [7:0] dataC;
		dsau_pkg::dsau_bus_t bus;
		logic [SRAM_DEPTH-1:0][7:0] mem;
	} dsau_regs_t;
	dsau_regs_t s;
	dsau_regs_t next_s;

	////////////////////////////////////////////////////////////////
	// bus timing for a stretch value

	function automatic logic [5:0] aleEndOf(input logic [2:0] st);
		aleEndOf = (st >= `DSAU_STRETCH_SLOW) ? `DSAU_SLOW_ALE_END : `DSAU_FAST_ALE_END;
	endfunction
	function automatic logic [5:0] strobeAtOf(input logic [2:0] st);
		if (st == 3'h0) begin
			strobeAtOf = `DSAU_FAST_STROBE_AT;
		end else if (st < `DSAU_STRETCH_SLOW) begin
			strobeAtOf = `DSAU_MID_STROBE_AT;
		end else begin
			strobeAtOf = `DSAU_SLOW_STROBE_AT;
		end
	endfunction
	function automatic logic [5:0] widthOf(input logic [2:0] st);
		// stretch 0 strobes for half a machine cycle
		widthOf = (st == 3'h0) ? `DSAU_FAST_STROBE : 6'({3'h0, st} * `DSAU_CLK_PER_MC);
	endfunction
	function automatic logic [5:0] totalOf(input logic [2:0] st);
		logic [5:0] extra;
		extra = (st >= `DSAU_STRETCH_SLOW) ? `DSAU_SLOW_EXTRA_MC : `DSAU_FAST_EXTRA_MC;
		totalOf = 6'((6'(st) + extra) * `DSAU_CLK_PER_MC);
	endfunction

	////////////////////////////////////////////////////////////////
	// next state

	logic [15:0] activePtr;
	logic [15:0] reqAddr;
	logic [5:0] n;
	logic [5:0] strobeEnd;
	logic toggleNow;
	logic inSram;
	always_comb begin
		next_s = s;
		activePtr = s.select[`DSAU_SEL_BIT] ? s.ptr1 : s.ptr0;
		reqAddr = movxReq.usePointer ? activePtr : movxReq.addr;
		n = 6'(s.cnt + 6'h01);
		strobeEnd = 6'(strobeAtOf(s.stretchUsed) + widthOf(s.stretchUsed));
		toggleNow = 1'b0;
		inSram = (reqAddr <= `DSAU_SRAM_TOP);
		next_s.done = 1'b0;

		// fuse pins: third stage trusted only when it agrees with the second
		next_s.lockA = securityLockPins;
		next_s.lockB = s.lockA;
		next_s.lockC = s.lockB;
		if (s.lockB == s.lockC) begin
			next_s.lockStatus = s.lockC;
		end
		next_s.dataA = port0In;
		next_s.dataB = s.dataA;
		next_s.dataC = s.dataB;

		// control writes; the map is sampled per request, no extra sequence
		if (mapWrite) begin
			next_s.mapSel = mapIn;
		end
		if (stretchWrite) begin
			next_s.stretch = stretchIn;
		end
		if (selectWrite) begin
			// bit 1 stays zero so an increment of the register flips select
			next_s.select = selectIn & `DSAU_SELECT_MASK;
		end

		// pointer instructions act on the active pointer first
		if (incPointer) begin
			if (!s.select[`DSAU_SEL_BIT]) begin
				next_s.ptr0 = s.select[`DSAU_DIR0_BIT] ? 16'(s.ptr0 - 16'h1)
					: 16'(s.ptr0 + 16'h1);
			end else begin
				next_s.ptr1 = s.select[`DSAU_DIR1_BIT] ? 16'(s.ptr1 - 16'h1)
					: 16'(s.ptr1 + 16'h1);
			end
			toggleNow = 1'b1;
		end
		if (loadPointer) begin
			if (!s.select[`DSAU_SEL_BIT]) begin
				next_s.ptr0 = loadValue;
			end else begin
				next_s.ptr1 = loadValue;
			end
			toggleNow = 1'b1;
		end
		if (codeReadPointer) begin
			toggleNow = 1'b1;
		end

		case (s.state)
			dsau_pkg::ST_IDLE: begin
				if (movxReq.valid) begin
					next_s.addr = reqAddr;
					next_s.write = movxReq.write;
					next_s.wrData = movxReq.wrData;
					next_s.stretchUsed = s.stretch;
					next_s.cnt = 6'h00;
					next_s.rdData = 8'h00;
					next_s.lastExt = 1'b0;
					if (movxReq.usePointer) begin
						toggleNow = 1'b1;
					end
					if (s.mapSel != `DSAU_MAP_EXTERNAL && s.mapSel != `DSAU_MAP_RESERVED
						&& inSram) begin
						// sram cycle: write now, read data ready at once
						next_s.state = dsau_pkg::ST_SRAM;
						if (movxReq.write) begin
							next_s.mem[reqAddr[`DSAU_SRAM_AW-1:0]] = movxReq.wrData;
						end else begin
							next_s.rdData = s.mem[reqAddr[`DSAU_SRAM_AW-1:0]];
						end
					end else if (s.mapSel == `DSAU_MAP_LOCKED) begin
						// no bus cycle; only the lock byte reads non-zero
						next_s.state = dsau_pkg::ST_LOCAL;
						if (!movxReq.write && reqAddr == `DSAU_LOCK_ADDR) begin
							next_s.rdData = {5'h00, s.lockStatus};
						end
					end else begin
						// reserved code 10 treated as external, the safe reading
						next_s.state = dsau_pkg::ST_EXT;
						next_s.lastExt = 1'b1;
						next_s.bus.port2Out = reqAddr[15:8];
						next_s.bus.port0Out = reqAddr[7:0];
						next_s.bus.port0Oe = 1'b1;
						next_s.bus.ale = 1'b1;
					end
				end
			end
			dsau_pkg::ST_SRAM, dsau_pkg::ST_LOCAL: begin
				next_s.cnt = n;
				if (n == `DSAU_SRAM_CLOCKS) begin
					next_s.done = 1'b1;
					next_s.state = dsau_pkg::ST_IDLE;
				end
			end
			dsau_pkg::ST_EXT: begin
				next_s.cnt = n;
				next_s.bus.ale = (n < aleEndOf(s.stretchUsed));
				if (n <= aleEndOf(s.stretchUsed)) begin
					next_s.bus.port0Out = s.addr[7:0];
					next_s.bus.port0Oe = 1'b1;
				end else begin
					next_s.bus.port0Out = s.write ? s.wrData : 8'h00;
					next_s.bus.port0Oe = s.write;
				end
				if (n >= strobeAtOf(s.stretchUsed) && n < strobeEnd) begin
					next_s.bus.readStrobe_n = s.write;
					next_s.bus.writeStrobe_n = !s.write;
				end else begin
					next_s.bus.readStrobe_n = 1'b1;
					next_s.bus.writeStrobe_n = 1'b1;
				end
				// sync lag: both compared stages then hold pins from inside the strobe
				if (!s.write && n == 6'(strobeEnd + 6'h02) && s.dataB == s.dataC) begin
					next_s.rdData = s.dataC;
				end
				if (n == totalOf(s.stretchUsed)) begin
					next_s.done = 1'b1;
					next_s.state = dsau_pkg::ST_IDLE;
					next_s.bus.port0Oe = 1'b0;
					next_s.bus.ale = 1'b0;
				end
			end
			default: begin
				next_s.state = dsau_pkg::ST_IDLE;
			end
		endcase

		if (toggleNow && s.select[`DSAU_TOGGLE_BIT] && !selectWrite) begin
			next_s.select[`DSAU_SEL_BIT] = !s.select[`DSAU_SEL_BIT];
		end
		next_s.busy = (next_s.state != dsau_pkg::ST_IDLE);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.state <= dsau_pkg::ST_IDLE;
			s.mapSel <= `DSAU_MAP_RESET;
			s.stretch <= `DSAU_STRETCH_RESET;
			s.select <= `DSAU_SELECT_RESET;
			s.bus.readStrobe_n <= 1'b1;
			s.bus.writeStrobe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign movxBusy = s.busy;
	assign movxDone = s.done;
	assign movxRdData = s.rdData;
	assign extBus = s.bus;
	assign dataMapSel = s.mapSel;
	assign movxStretchField = s.stretch;
	assign pointerSelectReg = s.select;
	assign firstDataPointer = s.ptr0;
	assign secondDataPointer = s.ptr1;
	assign securityLockBits = s.lockStatus;

	////////////////////////////////////////////////////////////////
	// checks

	logic [5:0] lowCount;
	logic [5:0] aleCount;
	// helper counters of strobe-low and ale-high lengths
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lowCount <= 6'h00;
			aleCount <= 6'h00;
		end else begin
			lowCount <= (!s.bus.readStrobe_n || !s.bus.writeStrobe_n) ? 6'(lowCount + 6'h01) : 6'h00;
			aleCount <= s.bus.ale ? 6'(aleCount + 6'h01) : 6'h00;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence startSram;
		s.state == dsau_pkg::ST_IDLE && movxReq.valid && s.mapSel[0] && inSram;
	endsequence
	sequence startExtDefault;
		s.state == dsau_pkg::ST_IDLE && movxReq.valid && s.mapSel == `DSAU_MAP_EXTERNAL;
	endsequence
	sequence strobeRelease;
		$rose(s.bus.readStrobe_n & s.bus.writeStrobe_n);
	endsequence

	sram_two_cycle_a: assert property (startSram |=> !s.done [*8] ##1 s.done)
		else $error("sram movx did not finish in two machine cycles");

	default_external_a: assert property (startExtDefault |=> s.bus.ale && s.lastExt)
		else $error("default map did not start an external cycle");

	sram_no_bus_a: assert property (startSram |=> !s.bus.ale [*8])
		else $error("sram access drove address latch");

	lock_byte_a: assert property (s.state == dsau_pkg::ST_IDLE && movxReq.valid
		&& !movxReq.write && s.mapSel == `DSAU_MAP_LOCKED && reqAddr == `DSAU_LOCK_ADDR
		|=> s.rdData == {5'h00, $past(s.lockStatus)} && !s.bus.ale)
		else $error("lock byte read returned wrong value");

	reserved_zero_a: assert property (s.state == dsau_pkg::ST_IDLE && movxReq.valid
		&& s.mapSel == `DSAU_MAP_LOCKED && !inSram && reqAddr != `DSAU_LOCK_ADDR
		|=> s.rdData == 8'h00 && s.state == dsau_pkg::ST_LOCAL)
		else $error("reserved address not answered locally with zero");

	ext_length_a: assert property (s.done && s.lastExt |-> s.cnt == totalOf(s.stretchUsed))
		else $error("external movx length does not match stretch");

	strobe_width_a: assert property (strobeRelease and s.lastExt
		|-> lowCount == widthOf(s.stretchUsed))
		else $error("strobe width does not match stretch");

	ale_width_a: assert property ($fell(s.bus.ale) && s.lastExt
		|-> aleCount == aleEndOf(s.stretchUsed)
		&& $past(aleCount) == 6'(aleEndOf(s.stretchUsed) - 6'h01))
		else $error("address latch width wrong for stretch");

	stretch_reset_a: assert property ($rose(reset_n) |-> s.stretch == `DSAU_STRETCH_RESET)
		else $error("stretch field not one after reset");

	inactive_kept_a: assert property (incPointer && !loadPointer && !s.select[`DSAU_SEL_BIT]
		|=> s.ptr1 == $past(s.ptr1))
		else $error("inactive pointer changed on increment");

	auto_toggle_a: assert property (incPointer && !selectWrite && s.select[`DSAU_TOGGLE_BIT]
		|=> s.select[`DSAU_SEL_BIT] != $past(s.select[`DSAU_SEL_BIT]))
		else $error("select did not toggle after pointer instruction");

endmodule // dsau_access_unit

// [dsau_ext_mem.sv]
// external data memory model on the multiplexed port 0 / port 2 bus
`timescale 1ns/1ps

module dsau_ext_mem (
	// clock
	input wire logic ref_clk,
	// bus from the unit
	input wire dsau_pkg::dsau_bus_t extBus,
	// pin level and observations
	output logic [7:0] port0In,
	output logic [15:0] lastAddr,
	output int aleCount,
	output int stbWidth
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastPin = 8'h00;
	logic [7:0] wrLatch;
	logic aleOld = 1'b0;
	logic stbOld = 1'b1;
	logic wrOld = 1'b1;
	logic holdRd = 1'b0;
	logic stb;
	int run = 0;
	initial aleCount = 0;
	initial stbWidth = 0;
	assign stb = extBus.readStrobe_n & extBus.writeStrobe_n;
	// released pins show the inverse of the last level, never a stale copy
	assign port0In = extBus.port0Oe ? extBus.port0Out :
		(!extBus.readStrobe_n || holdRd) ? mem[lastAddr] : ~lastPin;
	always @(posedge ref_clk) begin
		lastPin <= port0In;
		aleOld <= extBus.ale;
		stbOld <= stb;
		wrOld <= extBus.writeStrobe_n;
		// one clock of data hold after the read strobe, no more
		holdRd <= !extBus.readStrobe_n;
		if (extBus.ale) begin
			lastAddr <= {extBus.port2Out, extBus.port0Out};
		end
		if (aleOld && !extBus.ale) begin
			aleCount <= aleCount + 1;
		end
		if (!extBus.writeStrobe_n) begin
			wrLatch <= extBus.port0Out;
		end
		if (!wrOld && extBus.writeStrobe_n) begin
			mem[lastAddr] <= wrLatch;
		end
		run <= stb ? 0 : run + 1;
		if (stb && !stbOld) begin
			stbWidth <= run;
		end
	end
endmodule // dsau_ext_mem

// [dsau_access_unit_test.sv]
// self-checking bench of the data-space access unit
`timescale 1ns/1ps

module dsau_access_unit_test;
	typedef struct packed {
		logic [1:0] map;
		logic [2:0] st;
		logic wr;
		logic [15:0] addr;
		logic [7:0] dat;
		logic ext;
	} dsau_row_t;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic mapWrite = 1'b0, stretchWrite = 1'b0, selectWrite = 1'b0;
	logic incPointer = 1'b0, loadPointer = 1'b0, codeReadPointer = 1'b0;
	logic [1:0] mapIn = 2'h0;
	logic [2:0] stretchIn = 3'h0;
	logic [7:0] selectIn = 8'h00;
	logic [15:0] loadValue = 16'h0000;
	logic [2:0] lockPins = 3'h5;
	dsau_pkg::dsau_movx_t movxReq = '0;
	logic movxBusy, movxDone;
	logic [7:0] movxRdData, port0In, pointerSelectReg;
	dsau_pkg::dsau_bus_t extBus;
	logic [1:0] dataMapSel;
	logic [2:0] movxStretchField, securityLockBits;
	logic [15:0] firstDataPointer, secondDataPointer, lastAddr;
	int aleCount, stbWidth, errTotal = 0, nChecks = 0, n, c0;
	dsau_row_t r;
	logic [5:0] mcTab [0:7] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b, 6'h0c};
	dsau_row_t rows [0:20] = '{
		'{2'h0, 3'h1, 1'b1, 16'h0010, 8'ha5, 1'b1}, '{2'h0, 3'h1, 1'b0, 16'h0010, 8'ha5, 1'b1},
		'{2'h1, 3'h0, 1'b1, 16'h0010, 8'h3c, 1'b0}, '{2'h1, 3'h0, 1'b0, 16'h0010, 8'h3c, 1'b0},
		'{2'h1, 3'h7, 1'b1, 16'h03ff, 8'h77, 1'b0}, '{2'h1, 3'h7, 1'b0, 16'h03ff, 8'h77, 1'b0},
		'{2'h1, 3'h2, 1'b1, 16'h0400, 8'h5a, 1'b1}, '{2'h1, 3'h0, 1'b0, 16'h0400, 8'h5a, 1'b1},
		'{2'h0, 3'h0, 1'b0, 16'h0010, 8'ha5, 1'b1}, '{2'h0, 3'h4, 1'b1, 16'hffff, 8'hc3, 1'b1},
		'{2'h0, 3'h5, 1'b0, 16'hffff, 8'hc3, 1'b1}, '{2'h0, 3'h3, 1'b1, 16'h8001, 8'h11, 1'b1},
		'{2'h0, 3'h6, 1'b0, 16'h8001, 8'h11, 1'b1}, '{2'h0, 3'h7, 1'b0, 16'h0010, 8'ha5, 1'b1},
		'{2'h3, 3'h1, 1'b0, 16'h03ff, 8'h77, 1'b0}, '{2'h3, 3'h1, 1'b1, 16'hfffc, 8'hff, 1'b0},
		'{2'h3, 3'h1, 1'b0, 16'hfffc, 8'h05, 1'b0}, '{2'h3, 3'h1, 1'b0, 16'h0400, 8'h00, 1'b0},
		'{2'h3, 3'h7, 1'b1, 16'h0400, 8'h99, 1'b0}, '{2'h3, 3'h1, 1'b0, 16'hfffe, 8'h00, 1'b0},
		'{2'h1, 3'h0, 1'b0, 16'h0400, 8'h5a, 1'b1}};

	dsau_access_unit i_dsau_access_unit (.ref_clk(ref_clk), .reset_n(reset_n),
		.mapWrite(mapWrite), .mapIn(mapIn), .stretchWrite(stretchWrite), .stretchIn(stretchIn),
		.selectWrite(selectWrite), .selectIn(selectIn), .incPointer(incPointer),
		.loadPointer(loadPointer), .loadValue(loadValue), .codeReadPointer(codeReadPointer),
		.movxReq(movxReq), .movxBusy(movxBusy), .movxDone(movxDone), .movxRdData(movxRdData),
		.securityLockPins(lockPins), .port0In(port0In), .extBus(extBus),
		.dataMapSel(dataMapSel), .movxStretchField(movxStretchField),
		.pointerSelectReg(pointerSelectReg), .firstDataPointer(firstDataPointer),
		.secondDataPointer(secondDataPointer), .securityLockBits(securityLockBits));
	dsau_ext_mem i_dsau_ext_mem (.ref_clk(ref_clk), .extBus(extBus), .port0In(port0In),
		.lastAddr(lastAddr), .aleCount(aleCount), .stbWidth(stbWidth));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finalReport;
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	// the trailing tick keeps two pulses of one strobe a cycle apart
	task automatic strobe(input logic [3:0] which, input logic [15:0] v);
		{selectWrite, incPointer, loadPointer, codeReadPointer} = which;
		selectIn = v[7:0];
		loadValue = v;
		tick;
		{selectWrite, incPointer, loadPointer, codeReadPointer} = 4'h0;
		tick;
	endtask
	task automatic movx(input logic wr, input logic up, input logic [15:0] a,
		input logic [7:0] d);
		movxReq = '{1'b1, wr, up, a, d};
		tick;
		movxReq.valid = 1'b0;
		check(movxBusy, 1'b1);
		n = 0;
		while (movxDone !== 1'b1 && n < 100) begin
			tick;
			n++;
		end
		if (n >= 100) begin
			errTotal++;
			finalReport;
		end
		check(movxBusy, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) tick;
		reset_n = 1'b1;
		repeat (6) tick;
		check(securityLockBits, 3'h5);
		for (int i = 0; i < 21; i++) begin
			r = rows[i];
			{mapIn, stretchIn, mapWrite, stretchWrite} = {r.map, r.st, 2'h3}; // no row uses 10
			tick;
			{mapWrite, stretchWrite} = 2'h0;
			check(movxStretchField, r.st);
			check(dataMapSel, r.map);
			c0 = aleCount;
			movx(r.wr, 1'b0, r.addr, r.dat);
			check(n, r.ext ? 4 * mcTab[r.st] : 8);
			check(aleCount - c0, r.ext);
			if (!r.wr) check(movxRdData, r.dat);
			if (r.ext) check(lastAddr, r.addr);
			if (r.ext) check(stbWidth, r.st ? 4 * r.st : 2);
		end
		$display("movx map and stretch rows done");
		strobe(4'h8, 16'h0000);
		strobe(4'h2, 16'h1234);
		check(firstDataPointer, 16'h1234);
		strobe(4'h8, 16'h0060);
		strobe(4'h4, 16'h0000);
		check(firstDataPointer, 16'h1233);
		check(pointerSelectReg, 8'h61);
		strobe(4'h4, 16'h0000);
		check(secondDataPointer, 16'h0001);
		check(firstDataPointer, 16'h1233);
		strobe(4'h1, 16'h0000);
		check(pointerSelectReg, 8'h61);
		strobe(4'h8, 16'h00ff);
		check(pointerSelectReg, 8'he1);
		strobe(4'h4, 16'h0000);
		check(secondDataPointer, 16'h0000);
		strobe(4'h8, 16'h0000);
		strobe(4'h2, 16'h0010);
		strobe(4'h8, 16'h0020);
		movx(1'b0, 1'b1, 16'hffff, 8'h00);
		check(movxRdData, 8'h3c);
		check(pointerSelectReg, 8'h21);
		strobe(4'h2, 16'hbeef);
		check(secondDataPointer, 16'hbeef);
		check(pointerSelectReg, 8'h20);
		$display("pointer tests done");
		reset_n = 1'b0;
		repeat (10) tick;
		check(movxStretchField, 3'h1);
		check(dataMapSel, 2'h0);
		check(pointerSelectReg, 8'h00);
		reset_n = 1'b1;
		tick;
		c0 = aleCount;
		movx(1'b0, 1'b0, 16'h0010, 8'h00);
		check(n, 12);
		check(aleCount - c0, 1);
		check(movxRdData, 8'ha5);
		$display("mid-run reset test done");
		finalReport;
	end
endmodule // dsau_access_unit_test
